// *** disk_task_file_registers.sv ***
// Host-visible command-block register bank of the disk drive interface
`timescale 1ns/1ps

// Operation
// (RQ1) Writes ignore unused bits; reads return zero in unused bits.
// (RQ2) Index 0 moves 16-bit words between host and sector buffer.
// (RQ3) Host trusts error register only while status error bit is set.
// (RQ4) Bit 7 set on Ultra DMA interface CRC mismatch.
// (RQ5) Bit 6 set on uncorrectable data field read error.
// (RQ6) Bit 4 set when requested sector is not found.
// (RQ7) Bit 2 set when a command is aborted.
// (RQ8) Bit 1 set when recalibrate misses the home track.
// (RQ9) Bit 0 set when data address mark is missing.
// (RQ10) Bits 5 and 3 are removable-media flags; fixed drive leaves them.
// (RQ11) Power-on or diagnostics loads result code without status error.
// (RQ12) Codes 01..05 name diagnostic results; 06-7F reserved.
// (RQ13) Failing second drive ORs 80h into first drive's code.
// (RQ14) Write-only features register at index 1 holds subcommand.
// (RQ15) Count gives sectors, zero meaning 256; reads zero after completion.
// (RQ16) Per sector, count decrements and sector number advances.
// (RQ17) Initialize parameters takes count as sectors per track.
// (RQ18) Set-features with 03h takes count as transfer mode.
// (RQ19) CHS sector starts at 1, shows last or failing sector.
// (RQ20) LBA bits 0-7, 8-15, 16-23 in sector, low, high registers.
// (RQ21) CHS cylinder low byte in low, bits 15-8 in high.
// (RQ22) Host loads 4Fh and C2h into cylinder registers before SMART.
// (RQ23) Host selects with chip select, index lines, then strobe.
// (RQ24) Device/head select bit picks CHS or LBA meaning.
module disk_task_file_registers #(
   parameter int data_width = 16
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Host register access (active-low select and strobes)
   input wire logic i_primary_block_select_n,
   input wire logic [2:0] i_register_index_lines,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic [data_width-1:0] i_host_data,
   output logic [data_width-1:0] o_host_data,
   output logic o_host_data_oe,
   // DMA data path (same port, separate qualifier)
   input wire logic i_dma_active,
   // Sector buffer side
   input wire logic [data_width-1:0] i_buffer_rdata,
   output logic o_buffer_rd,
   output logic [data_width-1:0] o_buffer_wdata,
   output logic o_buffer_wr,
   // Command engine events
   input wire logic i_command_start,
   input wire logic i_link_checksum_fail,
   input wire logic i_data_unrecoverable,
   input wire logic i_sector_id_missing,
   input wire logic i_command_aborted,
   input wire logic i_home_track_missing,
   input wire logic i_address_mark_missing,
   input wire logic i_media_swapped,
   input wire logic i_media_eject_request,
   // Diagnostics
   input wire logic i_diag_done,
   input wire logic [7:0] i_diag_code,
   input wire logic i_second_drive_fail,
   // Sector progress
   input wire logic i_lba_mode,
   input wire logic i_sector_done,
   input wire logic i_track_wrap,
   input wire logic i_command_fail,
   // Parameter capture strobes
   input wire logic i_init_params,
   input wire logic i_set_features,
   // Values for the command engine
   output logic [7:0] o_feature_select,
   output logic [8:0] o_sectors_requested,
   output logic [7:0] o_sectors_per_track,
   output logic [7:0] o_transfer_mode,
   output logic o_smart_signature_ok,
   output logic [7:0] o_start_sector,
   output logic [15:0] o_track_addr,
   output logic o_diag_mode
);

   // =====================================================
   // Access decode
   // =====================================================
   logic rd_strobe_d;
   logic wr_strobe_d;
   logic rd_event;
   logic wr_event;
   logic selected;

   // Strobe edge detect: one access per host pulse
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_strobe_d <= 1'b0;
         wr_strobe_d <= 1'b0;
      end else begin
         rd_strobe_d <= !i_read_strobe_n;
         wr_strobe_d <= !i_write_strobe_n;
      end
   end

   assign selected = !i_primary_block_select_n; // RQ23
   assign rd_event = !i_read_strobe_n && !rd_strobe_d;
   assign wr_event = !i_write_strobe_n && !wr_strobe_d;

   function automatic logic hit(input logic [2:0] idx, input logic [2:0] target);
      hit = idx == target;
   endfunction

   logic data_access;
   logic wr_hit_count;
   logic wr_hit_sector;
   logic wr_hit_low;
   logic wr_hit_high;
   assign data_access = (selected || i_dma_active) && hit(i_register_index_lines, task_file_pkg::idx_data_port);
   assign wr_hit_count = selected && wr_event && hit(i_register_index_lines, task_file_pkg::idx_transfer_count);
   assign wr_hit_sector = selected && wr_event && hit(i_register_index_lines, task_file_pkg::idx_start_sector);
   assign wr_hit_low = selected && wr_event && hit(i_register_index_lines, task_file_pkg::idx_track_low);
   assign wr_hit_high = selected && wr_event && hit(i_register_index_lines, task_file_pkg::idx_track_high);

   // =====================================================
   // Data port
   // =====================================================
   // Word path straight to the sector buffer, PIO or DMA
   assign o_buffer_rd = data_access && rd_event; // RQ2
   assign o_buffer_wr = data_access && wr_event; // RQ2
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_buffer_wdata <= task_file_pkg::reset_word;
      end else if (data_access && wr_event) begin
         o_buffer_wdata <= i_host_data; // RQ2
      end
   end

   // =====================================================
   // Error register
   // =====================================================
   logic [7:0] error_flags;
   logic [7:0] event_bits;

   // Event vector, one position per engine fault input
   always_comb begin
      event_bits = task_file_pkg::reset_zero;
      event_bits[task_file_pkg::bit_link_checksum_fail] = i_link_checksum_fail; // RQ4
      event_bits[task_file_pkg::bit_data_unrecoverable] = i_data_unrecoverable; // RQ5
      event_bits[task_file_pkg::bit_sector_id_missing] = i_sector_id_missing; // RQ6
      event_bits[task_file_pkg::bit_command_aborted] = i_command_aborted; // RQ7
      event_bits[task_file_pkg::bit_home_track_missing] = i_home_track_missing; // RQ8
      event_bits[task_file_pkg::bit_address_mark_missing] = i_address_mark_missing; // RQ9
      // Fixed drive: these inputs are tied low by the integrator
      event_bits[task_file_pkg::bit_media_swapped] = i_media_swapped; // RQ10
      event_bits[task_file_pkg::bit_media_eject_request] = i_media_eject_request; // RQ10
   end

   // Power-on counts as a passed self-test, so the error register shows that code
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         error_flags <= task_file_pkg::diag_no_error; // RQ11 RQ12
         o_diag_mode <= 1'b1; // RQ11
      end else if (i_diag_done) begin
         // Diagnostic code replaces flags; status error bit stays untouched
         error_flags <= i_second_drive_fail ? (task_file_pkg::diag_second_drive_fail | i_diag_code)
                                            : i_diag_code; // RQ11 RQ12 RQ13
         o_diag_mode <= 1'b1; // RQ11
      end else if (i_command_start) begin
         // Flags describe the last command only; an event in the start cycle still lands
         error_flags <= event_bits;
         o_diag_mode <= 1'b0;
      end else begin
         // Sticky until the next command start or diagnostic result
         error_flags <= error_flags | event_bits;
      end
   end

   // =====================================================
   // Features, count, sector and cylinder registers
   // =====================================================
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_feature_select <= task_file_pkg::reset_zero;
      end else if (selected && wr_event && hit(i_register_index_lines, task_file_pkg::idx_error_feature)) begin
         o_feature_select <= i_host_data[7:0]; // RQ14 RQ1
      end
   end

   logic [7:0] transfer_count;
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         transfer_count <= task_file_pkg::count_one;
      end else if (wr_hit_count) begin
         transfer_count <= i_host_data[7:0]; // RQ1
      end else if (i_sector_done && !i_command_fail) begin
         // Wraps 0 -> ff on the first of 256, reaches zero at completion
         transfer_count <= transfer_count - task_file_pkg::count_one; // RQ15 RQ16
      end
   end
   assign o_sectors_requested = (transfer_count == task_file_pkg::reset_zero) ? 9'h100 : {1'b0, transfer_count}; // RQ15

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sectors_per_track <= task_file_pkg::reset_zero;
         o_transfer_mode <= task_file_pkg::reset_zero;
      end else begin
         if (i_init_params) o_sectors_per_track <= transfer_count; // RQ17
         if (i_set_features && o_feature_select == task_file_pkg::feature_transfer_mode)
            o_transfer_mode <= transfer_count; // RQ18
      end
   end

   // Sector advances only after a clean sector, so a failure leaves the failing one
   logic [7:0] start_sector;
   logic [15:0] track_addr;
   logic [23:0] lba_next;
   assign lba_next = {track_addr, start_sector} + 24'h000001;
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         start_sector <= task_file_pkg::first_chs_sector;
         track_addr <= task_file_pkg::reset_word;
      end else begin
         if (wr_hit_sector) start_sector <= i_host_data[7:0];
         if (wr_hit_low) track_addr[7:0] <= i_host_data[7:0]; // RQ21 RQ22
         if (wr_hit_high) track_addr[15:8] <= i_host_data[7:0]; // RQ21 RQ22
         if (i_sector_done && !i_command_fail && transfer_count != task_file_pkg::count_one) begin
            if (i_lba_mode) begin
               {track_addr, start_sector} <= lba_next; // RQ20 RQ24
            end else if (i_track_wrap) begin
               start_sector <= task_file_pkg::first_chs_sector; // RQ19
            end else begin
               start_sector <= start_sector + task_file_pkg::count_one; // RQ16 RQ19
            end
         end
      end
   end
   assign o_start_sector = start_sector;
   assign o_track_addr = track_addr;
   assign o_smart_signature_ok = track_addr[7:0] == task_file_pkg::smart_sig_low
                                 && track_addr[15:8] == task_file_pkg::smart_sig_high; // RQ22

   // =====================================================
   // Read mux
   // =====================================================
   logic [data_width-1:0] next_host_data;
   always_comb begin
      next_host_data = '0; // RQ1
      case (i_register_index_lines)
         task_file_pkg::idx_data_port: next_host_data = i_buffer_rdata;
         task_file_pkg::idx_error_feature: next_host_data[7:0] = error_flags; // RQ3
         task_file_pkg::idx_transfer_count: next_host_data[7:0] = transfer_count;
         task_file_pkg::idx_start_sector: next_host_data[7:0] = start_sector;
         task_file_pkg::idx_track_low: next_host_data[7:0] = track_addr[7:0];
         task_file_pkg::idx_track_high: next_host_data[7:0] = track_addr[15:8];
         default: next_host_data = '0;
      endcase
   end

   logic mapped;
   assign mapped = i_register_index_lines <= task_file_pkg::idx_track_high;
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_host_data <= task_file_pkg::reset_word;
      end else if ((selected || i_dma_active) && rd_event) begin
         o_host_data <= next_host_data;
      end
   end
   assign o_host_data_oe = (selected || (i_dma_active && data_access)) && !i_read_strobe_n && rd_strobe_d && mapped;

endmodule

// *** task_file_pkg.sv ***
// Shared constants for the task-file register bank
package task_file_pkg;
   // Register indices on the three index lines
   localparam logic [2:0] idx_data_port = 3'h0;
   localparam logic [2:0] idx_error_feature = 3'h1;
   localparam logic [2:0] idx_transfer_count = 3'h2;
   localparam logic [2:0] idx_start_sector = 3'h3;
   localparam logic [2:0] idx_track_low = 3'h4;
   localparam logic [2:0] idx_track_high = 3'h5;
   // Operational error bit positions
   localparam int bit_link_checksum_fail = 7;
   localparam int bit_data_unrecoverable = 6;
   localparam int bit_media_swapped = 5;
   localparam int bit_sector_id_missing = 4;
   localparam int bit_media_eject_request = 3;
   localparam int bit_command_aborted = 2;
   localparam int bit_home_track_missing = 1;
   localparam int bit_address_mark_missing = 0;
   // Diagnostic result codes
   localparam logic [7:0] diag_no_error = 8'h01;
   localparam logic [7:0] diag_register_fault = 8'h02;
   localparam logic [7:0] diag_buffer_fault = 8'h03;
   localparam logic [7:0] diag_ecc_fault = 8'h04;
   localparam logic [7:0] diag_processor_fault = 8'h05;
   localparam logic [7:0] diag_second_drive_fail = 8'h80;
   // Feature and signature values
   localparam logic [7:0] feature_transfer_mode = 8'h03;
   localparam logic [7:0] smart_sig_low = 8'h4f;
   localparam logic [7:0] smart_sig_high = 8'hc2;
   // Reset and addressing values
   localparam logic [7:0] reset_zero = 8'h00;
   localparam logic [7:0] first_chs_sector = 8'h01;
   localparam logic [15:0] reset_word = 16'h0000;
   localparam logic [7:0] count_one = 8'h01;
endpackage

// *** task_file_chk.sv ***
// Port-level assertions for the task-file register bank
`timescale 1ns/1ps
module task_file_chk (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Host access
   input wire logic i_primary_block_select_n,
   input wire logic [2:0] i_register_index_lines,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic [15:0] i_host_data,
   input wire logic [15:0] o_host_data,
   input wire logic o_host_data_oe,
   input wire logic o_buffer_rd,
   input wire logic o_buffer_wr,
   input wire logic [15:0] o_buffer_wdata,
   // Engine side
   input wire logic i_diag_done,
   input wire logic i_init_params,
   input wire logic i_set_features,
   input wire logic [7:0] o_feature_select,
   input wire logic [8:0] o_sectors_requested,
   input wire logic [7:0] o_sectors_per_track,
   input wire logic [7:0] o_transfer_mode,
   input wire logic o_smart_signature_ok,
   input wire logic [15:0] o_track_addr,
   input wire logic o_diag_mode
);
   logic rd_q;
   logic wr_q;
   logic tr;
   logic tw;
   logic [2:0] ix;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // =========================
   // Strobe edge detection
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_q <= 1'b1;
         wr_q <= 1'b1;
      end else begin
         rd_q <= i_read_strobe_n;
         wr_q <= i_write_strobe_n;
      end
   end
   assign tr = rd_q && !i_read_strobe_n && !i_primary_block_select_n;
   assign tw = wr_q && !i_write_strobe_n && !i_primary_block_select_n;
   assign ix = i_register_index_lines;
   a_unused_zero: assert property (tr && ix[2:1] == 2'b11 |=> o_host_data == 16'h0000)
      else $error("unmapped read not zero");
   a_count_req: assert property (tw && ix == 3'h2 |=> o_sectors_requested ==
      ($past(i_host_data[7:0]) == 8'h00 ? 9'h100 : {1'b0, $past(i_host_data[7:0])}))
      else $error("requested count wrong");
   a_buf_wr: assert property (tw && ix == 3'h0 |-> ##[0:1] o_buffer_wr)
      else $error("no buffer write pulse");
   a_buf_pulse: assert property (o_buffer_wr |=> !o_buffer_wr)
      else $error("buffer write pulse too long");
   a_buf_word: assert property (tw && ix == 3'h0 |=> o_buffer_wdata == $past(i_host_data))
      else $error("buffer word wrong");
   a_feat_wr: assert property (tw && ix == 3'h1 |=> o_feature_select == $past(i_host_data[7:0]))
      else $error("features not written");
   a_track_low: assert property (tw && ix == 3'h4 |=> o_track_addr[7:0] == $past(i_host_data[7:0]))
      else $error("low track byte wrong");
   a_track_high: assert property (tw && ix == 3'h5 |=> o_track_addr[15:8] == $past(i_host_data[7:0]))
      else $error("high track byte wrong");
   a_smart_off: assert property (tw && ix == 3'h5 && i_host_data[7:0] != 8'hc2 |=> !o_smart_signature_ok)
      else $error("signature flag without signature");
   a_mode_load: assert property (i_set_features && o_feature_select == 8'h03
      |=> o_transfer_mode == $past(o_sectors_requested[7:0]))
      else $error("transfer mode not loaded");
   a_spt_load: assert property (i_init_params |=> o_sectors_per_track == $past(o_sectors_requested[7:0]))
      else $error("sectors per track not loaded");
   a_diag_enter: assert property (i_diag_done |=> o_diag_mode)
      else $error("diagnostic mode not entered");
   a_oe_mapped: assert property (tr && ix == 3'h2 |=> o_host_data_oe)
      else $error("bus not driven on register read");
   a_oe_unmapped: assert property (tr && ix[2:1] == 2'b11 |=> !o_host_data_oe)
      else $error("bus driven on unmapped read");
   a_buf_rd: assert property (tr && ix == 3'h0 |-> o_buffer_rd)
      else $error("no buffer read pulse");
endmodule
bind disk_task_file_registers task_file_chk u_chk (.i_mclk, .i_resetn, .i_primary_block_select_n,
   .i_register_index_lines, .i_read_strobe_n, .i_write_strobe_n, .i_host_data, .o_host_data,
   .o_host_data_oe, .o_buffer_rd, .o_buffer_wr,
   .o_buffer_wdata, .i_diag_done, .i_init_params, .i_set_features, .o_feature_select, .o_sectors_requested,
   .o_sectors_per_track, .o_transfer_mode, .o_smart_signature_ok, .o_track_addr, .o_diag_mode);

// *** host_model.sv ***
// Host controller model driving programmed register cycles
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk,
   // Register access
   output logic sel_n,
   output logic [2:0] idx,
   output logic rd_n,
   output logic wr_n,
   output logic [15:0] dout,
   input wire logic [15:0] din
);
   initial begin
      sel_n = 1'b1;
      idx = 3'h0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      dout = 16'h0000;
   end
   // =========================
   // Bus cycles: select, index and strobe driven on the same edge, gap after
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      sel_n <= 1'b0;
      idx <= a;
      dout <= d;
      wr_n <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      wr_n <= 1'b1;
      sel_n <= 1'b1;
      dout <= ~d; // Released bus never shows stale data
      @(posedge clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] q);
      @(posedge clk);
      sel_n <= 1'b0;
      idx <= a;
      rd_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 q = din;
      @(posedge clk);
      rd_n <= 1'b1;
      sel_n <= 1'b1;
      @(posedge clk);
   endtask
endmodule

// *** disk_task_file_registers_tb.sv ***
// Self-checking bench for the task-file register bank
`timescale 1ns/1ps
module disk_task_file_registers_tb;
   logic i_mclk = 1'b0, i_resetn = 1'b0, i_read_strobe_n, i_write_strobe_n, i_primary_block_select_n;
   logic [2:0] i_register_index_lines;
   logic [15:0] i_host_data, i_buffer_rdata = 16'h0000, o_host_data, o_buffer_wdata, o_track_addr, q;
   logic [12:0] p = 13'h0000;
   logic [7:0] i_diag_code = 8'h00, o_feature_select, o_sectors_per_track, o_transfer_mode, o_start_sector;
   logic i_second_drive_fail = 1'b0, i_lba_mode = 1'b0, o_host_data_oe, o_buffer_rd, o_buffer_wr;
   logic o_smart_signature_ok, o_diag_mode;
   logic [8:0] o_sectors_requested;
   int n_mismatch = 0, n_tests = 0;
   initial forever #20 i_mclk = ~i_mclk;
   host_model i_host (.clk(i_mclk), .sel_n(i_primary_block_select_n), .idx(i_register_index_lines),
      .rd_n(i_read_strobe_n), .wr_n(i_write_strobe_n), .dout(i_host_data), .din(o_host_data));
   disk_task_file_registers i_dut (.i_mclk, .i_resetn, .i_primary_block_select_n, .i_register_index_lines,
      .i_read_strobe_n, .i_write_strobe_n, .i_host_data, .o_host_data, .o_host_data_oe, .i_dma_active(1'b0),
      .i_buffer_rdata, .o_buffer_rd, .o_buffer_wdata, .o_buffer_wr, .i_command_start(p[8]),
      .i_link_checksum_fail(p[7]), .i_data_unrecoverable(p[6]), .i_sector_id_missing(p[4]),
      .i_command_aborted(p[2]), .i_home_track_missing(p[1]), .i_address_mark_missing(p[0]),
      .i_media_swapped(p[5]), .i_media_eject_request(p[3]), .i_diag_done(p[9]), .i_diag_code,
      .i_second_drive_fail, .i_lba_mode, .i_sector_done(p[10]), .i_track_wrap(1'b0), .i_command_fail(1'b0),
      .i_init_params(p[11]), .i_set_features(p[12]), .o_feature_select, .o_sectors_requested,
      .o_sectors_per_track, .o_transfer_mode, .o_smart_signature_ok, .o_start_sector, .o_track_addr,
      .o_diag_mode);
   // =========================
   // Shared checking tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [2:0] a, input logic [15:0] exp);
      i_host.rd(a, q);
      chk(q, exp);
   endtask
   task automatic pulse(input logic [12:0] v);
      @(posedge i_mclk);
      p <= v;
      @(posedge i_mclk);
      p <= 13'h0000;
      @(negedge i_mclk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (3) @(posedge i_mclk);
      i_resetn <= 1'b1;
      rc(3'h1, 16'h0001);
      chk({15'h0000, o_diag_mode}, 16'h0001);
      rc(3'h6, 16'h0000);
      rc(3'h7, 16'h0000);
      i_host.wr(3'h2, 16'hff05);
      rc(3'h2, 16'h0005);
      // Diagnostic codes; error register read outside operational mode
      i_diag_code <= 8'h03;
      pulse(13'h0200);
      rc(3'h1, 16'h0003);
      i_diag_code <= 8'h02;
      i_second_drive_fail <= 1'b1;
      pulse(13'h0200);
      rc(3'h1, 16'h0082);
      for (int b = 0; b < 8; b++) begin
         pulse(13'h0100);
         pulse(13'h0001 << b);
         rc(3'h1, 16'h0001 << b);
      end
      chk({15'h0000, o_diag_mode}, 16'h0000);
      i_host.wr(3'h1, 16'h0003);
      i_host.wr(3'h2, 16'h0042);
      pulse(13'h1800);
      chk({8'h00, o_feature_select}, 16'h0003);
      chk({8'h00, o_transfer_mode}, 16'h0042);
      chk({8'h00, o_sectors_per_track}, 16'h0042);
      i_host.wr(3'h1, 16'h0004);
      i_host.wr(3'h2, 16'h0000);
      pulse(13'h1000);
      chk({8'h00, o_transfer_mode}, 16'h0042);
      chk({7'h00, o_sectors_requested}, 16'h0100);
      // Two-sector transfer in cylinder-head-sector form
      i_host.wr(3'h2, 16'h0002);
      i_host.wr(3'h3, 16'h0005);
      i_host.wr(3'h4, 16'h0034);
      i_host.wr(3'h5, 16'h0012);
      chk(o_track_addr, 16'h1234);
      pulse(13'h0400);
      rc(3'h2, 16'h0001);
      rc(3'h3, 16'h0006);
      chk({8'h00, o_start_sector}, 16'h0006);
      pulse(13'h0400);
      rc(3'h2, 16'h0000);
      rc(3'h3, 16'h0006);
      // Carry across all three address bytes in block-address form
      i_lba_mode <= 1'b1;
      i_host.wr(3'h3, 16'h00ff);
      i_host.wr(3'h4, 16'h00ff);
      i_host.wr(3'h5, 16'h0000);
      i_host.wr(3'h2, 16'h0002);
      pulse(13'h0400);
      rc(3'h3, 16'h0000);
      rc(3'h4, 16'h0000);
      rc(3'h5, 16'h0001);
      i_lba_mode <= 1'b0;
      i_host.wr(3'h4, 16'h004f);
      i_host.wr(3'h5, 16'h00c2);
      chk({15'h0000, o_smart_signature_ok}, 16'h0001);
      i_buffer_rdata <= 16'ha55a;
      rc(3'h0, 16'ha55a);
      i_host.wr(3'h0, 16'h1234);
      chk(o_buffer_wdata, 16'h1234);
      end_sim;
   end
endmodule
